// File: rtl/crm_pkg.sv
// Package with register map, field layout and reset values of the CAN reset-mode control block
package crm_pkg;

  // ==========================================================================
  // Register word indices on the plain register port
  localparam logic [4:0] CRM_ADR_MAIN_CTRL = 5'h00;
  localparam logic [4:0] CRM_ADR_STATE_WORD = 5'h01;
  localparam logic [4:0] CRM_ADR_ERR_IRQ = 5'h02;
  localparam logic [4:0] CRM_ADR_RX_ERR = 5'h03;
  localparam logic [4:0] CRM_ADR_TX_ERR = 5'h04;
  localparam logic [4:0] CRM_ADR_STAMP = 5'h05;
  localparam logic [4:0] CRM_ADR_SRCH_STAT = 5'h06;
  localparam logic [4:0] CRM_ADR_SRCH_MODE = 5'h07;
  localparam logic [4:0] CRM_ADR_RX_FIFO = 5'h08;
  localparam logic [4:0] CRM_ADR_TX_FIFO = 5'h09;
  localparam logic [4:0] CRM_ADR_TEST = 5'h0a;
  localparam logic [4:0] CRM_ADR_ERR_CODE = 5'h0b;
  localparam logic [4:0] CRM_ADR_MBX_BASE = 5'h10;

  // ==========================================================================
  // Operating-mode request encodings (main_control[1:0])
  localparam logic [1:0] CRM_MODE_OPERATE = 2'h0;
  localparam logic [1:0] CRM_MODE_GRACE = 2'h1;
  localparam logic [1:0] CRM_MODE_HALT = 2'h2;
  localparam logic [1:0] CRM_MODE_FORCED = 2'h3;
  localparam logic [1:0] CRM_MODE_RST_VAL = CRM_MODE_GRACE;

  // ==========================================================================
  // state_word bit positions
  localparam int CRM_SW_RESET_MODE = 0;
  localparam int CRM_SW_DRAINING = 1;
  localparam int CRM_SW_TX_BUSY = 2;
  localparam int CRM_SW_RX_DONE = 3;
  localparam int CRM_SW_TX_FIFO = 4;
  localparam int CRM_SW_SLEEP = 5;

  // err_code_store display-mode bit
  localparam int CRM_EC_DISP_MODE = 7;

  // ==========================================================================
  // Initial values loaded on reset-mode entry, and the error-counter saturation limit
  localparam logic [7:0] CRM_INIT_BYTE = 8'h00;
  localparam logic [15:0] CRM_INIT_STAMP = 16'h0000;
  localparam logic [1:0] CRM_INIT_SRCH_MODE = 2'h0;
  localparam logic [7:0] CRM_ERR_CNT_MAX = 8'hff;

  typedef enum logic [1:0] {
    CRM_ST_OPER,
    CRM_ST_DRAIN,
    CRM_ST_RESET
  } crm_state_t;

endpackage : crm_pkg

// File: rtl/crm_byte_order.sv
// Byte-lane swapper that maps a 16-bit word between big- and little-endian order
`timescale 1ns/1ps
module crm_byte_order (
  input wire logic big_endian_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o
);

  // ==========================================================================
  // Swap lanes only in big-endian systems; the core always works little-endian
  assign data_o = big_endian_i ? {data_i[7:0], data_i[15:8]} : data_i;

endmodule : crm_byte_order

// File: rtl/crm_reset_ctrl.sv
// CAN controller reset-mode control with its register file and endian-aware register port
`timescale 1ns/1ps
module crm_reset_ctrl import crm_pkg::*; #(
  parameter int MBX_N = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  input wire logic bus_big_endian_i,
  input wire logic tx_busy_i,
  input wire logic rx_busy_i,
  input wire logic rx_done_i,
  input wire logic sleep_status_i,
  input wire logic tx_fifo_status_i,
  input wire logic [7:0] err_event_i,
  input wire logic rx_err_inc_i,
  input wire logic tx_err_inc_i,
  input wire logic stamp_tick_i,
  input wire logic [7:0] search_result_i,
  output logic in_reset_mode_o,
  output logic [1:0] op_mode_o
);

  // ==========================================================================
  // State and register storage
  crm_state_t state;
  crm_state_t next_state;
  logic [1:0] op_mode_request;
  logic [7:0] mailbox_ctrl [MBX_N];
  logic [7:0] err_irq_flags;
  logic [7:0] rx_err_count;
  logic [7:0] tx_err_count;
  logic [15:0] stamp_value;
  logic [7:0] mbx_search_status;
  logic [1:0] mbx_search_mode;
  logic [7:0] rx_fifo_ctrl;
  logic [7:0] tx_fifo_ctrl;
  logic [7:0] test_ctrl;
  logic [6:0] err_code_low;
  logic err_display_mode;
  logic rx_done_flag;

  // Saturating up-count used by both error counters
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == CRM_ERR_CNT_MAX) ? v : v + 8'h01;
  endfunction : sat_inc

  // ==========================================================================
  // Register port decode; write data are brought to core order first
  wire [15:0] wdata_le;
  wire [15:0] rd_le;
  wire [15:0] rd_sw;
  wire in_reset = (state == CRM_ST_RESET);
  wire wr_main = reg_we_i && (reg_addr_i == CRM_ADR_MAIN_CTRL);
  wire wr_state = reg_we_i && (reg_addr_i == CRM_ADR_STATE_WORD);
  wire wr_irq = reg_we_i && (reg_addr_i == CRM_ADR_ERR_IRQ);
  wire wr_smode = reg_we_i && (reg_addr_i == CRM_ADR_SRCH_MODE);
  wire wr_rxf = reg_we_i && (reg_addr_i == CRM_ADR_RX_FIFO);
  wire wr_txf = reg_we_i && (reg_addr_i == CRM_ADR_TX_FIFO);
  wire wr_test = reg_we_i && (reg_addr_i == CRM_ADR_TEST);
  wire wr_ecode = reg_we_i && (reg_addr_i == CRM_ADR_ERR_CODE);
  wire mbx_hit = (reg_addr_i >= CRM_ADR_MBX_BASE) && (32'(reg_addr_i - CRM_ADR_MBX_BASE) < MBX_N);
  wire [4:0] mbx_idx = reg_addr_i - CRM_ADR_MBX_BASE;

  crm_byte_order u_wr_order (
    .big_endian_i(bus_big_endian_i),
    .data_i(reg_wdata_i),
    .data_o(wdata_le)
  );

  // ==========================================================================
  // Mode sequencer: graceful entry waits for transmission only
  always_comb begin
    next_state = state;
    case (state)
      CRM_ST_OPER: begin
        if (op_mode_request == CRM_MODE_FORCED) begin
          next_state = CRM_ST_RESET;
        end else if (op_mode_request == CRM_MODE_GRACE) begin
          next_state = tx_busy_i ? CRM_ST_DRAIN : CRM_ST_RESET;
        end
      end
      CRM_ST_DRAIN: begin
        if (op_mode_request == CRM_MODE_FORCED) begin
          next_state = CRM_ST_RESET;
        end else if (op_mode_request != CRM_MODE_GRACE) begin
          next_state = CRM_ST_OPER;
        end else if (!tx_busy_i) begin
          next_state = CRM_ST_RESET;
        end
      end
      CRM_ST_RESET: begin
        if (!op_mode_request[0]) begin
          next_state = CRM_ST_OPER;
        end
      end
      default: next_state = CRM_ST_RESET;
    endcase
  end

  // Sequencer state and software mode request; the block leaves reset in reset mode
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state <= CRM_ST_RESET;
      op_mode_request <= CRM_MODE_RST_VAL;
    end else begin
      state <= next_state;
      if (wr_main) begin
        op_mode_request <= wdata_le[1:0];
      end
    end
  end

  // ==========================================================================
  // Mailbox controls: cleared each cycle in reset mode, so entry and hold are one path
  always_ff @(posedge core_clk_i) begin
    for (int j = 0; j < MBX_N; j++) begin
      if (!resetn_i || in_reset) begin
        mailbox_ctrl[j] <= CRM_INIT_BYTE;
      end else if (reg_we_i && mbx_hit && (mbx_idx == 5'(j))) begin
        mailbox_ctrl[j] <= wdata_le[7:0];
      end
    end
  end

  // Error flags: hardware set wins over a software clear (write 0 clears a bit)
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || in_reset) begin
      err_irq_flags <= CRM_INIT_BYTE;
    end else begin
      err_irq_flags <= (wr_irq ? (err_irq_flags & wdata_le[7:0]) : err_irq_flags) | err_event_i;
    end
  end

  // Error counters and time stamp stop while reset mode holds them
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || in_reset) begin
      rx_err_count <= CRM_INIT_BYTE;
      tx_err_count <= CRM_INIT_BYTE;
      stamp_value <= CRM_INIT_STAMP;
    end else begin
      if (rx_err_inc_i) begin
        rx_err_count <= sat_inc(rx_err_count);
      end
      if (tx_err_inc_i) begin
        tx_err_count <= sat_inc(tx_err_count);
      end
      if (stamp_tick_i) begin
        stamp_value <= stamp_value + 16'h0001;
      end
    end
  end

  // Search, FIFO and test controls; software writes are ignored in reset mode
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || in_reset) begin
      mbx_search_status <= CRM_INIT_BYTE;
      mbx_search_mode <= CRM_INIT_SRCH_MODE;
      rx_fifo_ctrl <= CRM_INIT_BYTE;
      tx_fifo_ctrl <= CRM_INIT_BYTE;
      test_ctrl <= CRM_INIT_BYTE;
    end else begin
      mbx_search_status <= search_result_i;
      if (wr_smode) begin
        mbx_search_mode <= wdata_le[1:0];
      end
      if (wr_rxf) begin
        rx_fifo_ctrl <= wdata_le[7:0];
      end
      if (wr_txf) begin
        tx_fifo_ctrl <= wdata_le[7:0];
      end
      if (wr_test) begin
        test_ctrl <= wdata_le[7:0];
      end
    end
  end

  // Error code store: the display-mode bit survives reset mode
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      err_code_low <= 7'h00;
      err_display_mode <= 1'b0;
    end else begin
      if (in_reset) begin
        err_code_low <= 7'h00;
      end else if (wr_ecode) begin
        err_code_low <= wdata_le[6:0];
      end
      if (wr_ecode) begin
        err_display_mode <= wdata_le[CRM_EC_DISP_MODE];
      end
    end
  end

  // Sticky receive flag in the state word; set wins over a write-0 clear
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || in_reset) begin
      rx_done_flag <= 1'b0;
    end else begin
      rx_done_flag <= rx_done_i | (rx_done_flag & !(wr_state && !wdata_le[CRM_SW_RX_DONE]));
    end
  end

  // ==========================================================================
  // State word: sleep and FIFO flags are wired live, never initialised
  wire [15:0] state_word;
  assign state_word[CRM_SW_RESET_MODE] = in_reset;
  assign state_word[CRM_SW_DRAINING] = (state == CRM_ST_DRAIN);
  assign state_word[CRM_SW_TX_BUSY] = tx_busy_i & !in_reset;
  assign state_word[CRM_SW_RX_DONE] = rx_done_flag;
  assign state_word[CRM_SW_TX_FIFO] = tx_fifo_status_i;
  assign state_word[CRM_SW_SLEEP] = sleep_status_i;
  assign state_word[15:6] = 10'h000;

  // Read selection in core order; unmapped words read as zero
  wire [15:0] rd_mbx = mbx_hit ? {8'h00, mailbox_ctrl[mbx_idx[$clog2(MBX_N)-1:0]]} : 16'h0000;
  assign rd_le =
    (reg_addr_i == CRM_ADR_MAIN_CTRL) ? {14'h0000, op_mode_request} :
    (reg_addr_i == CRM_ADR_STATE_WORD) ? state_word :
    (reg_addr_i == CRM_ADR_ERR_IRQ) ? {8'h00, err_irq_flags} :
    (reg_addr_i == CRM_ADR_RX_ERR) ? {8'h00, rx_err_count} :
    (reg_addr_i == CRM_ADR_TX_ERR) ? {8'h00, tx_err_count} :
    (reg_addr_i == CRM_ADR_STAMP) ? stamp_value :
    (reg_addr_i == CRM_ADR_SRCH_STAT) ? {8'h00, mbx_search_status} :
    (reg_addr_i == CRM_ADR_SRCH_MODE) ? {14'h0000, mbx_search_mode} :
    (reg_addr_i == CRM_ADR_RX_FIFO) ? {8'h00, rx_fifo_ctrl} :
    (reg_addr_i == CRM_ADR_TX_FIFO) ? {8'h00, tx_fifo_ctrl} :
    (reg_addr_i == CRM_ADR_TEST) ? {8'h00, test_ctrl} :
    (reg_addr_i == CRM_ADR_ERR_CODE) ? {8'h00, err_display_mode, err_code_low} :
    rd_mbx;

  crm_byte_order u_rd_order (
    .big_endian_i(bus_big_endian_i),
    .data_i(rd_le),
    .data_o(rd_sw)
  );

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_sw : 16'h0000;
    end
  end

  assign in_reset_mode_o = in_reset;
  assign op_mode_o = op_mode_request;

  // ==========================================================================
  // Checks on the mode sequencer, the held registers and the register read port
  chk_forced_entry: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (op_mode_request == CRM_MODE_FORCED) |=> (state == CRM_ST_RESET))
    else $error("forced request did not reach reset mode in one cycle");

  chk_grace_waits: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state != CRM_ST_RESET && op_mode_request == CRM_MODE_GRACE && tx_busy_i) |=> (state != CRM_ST_RESET))
    else $error("graceful entry did not wait for transmission");

  chk_grace_ignores_rx: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (op_mode_request == CRM_MODE_GRACE && !tx_busy_i && rx_busy_i) |=> in_reset_mode_o)
    else $error("graceful entry waited on reception");

  chk_regs_held: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    in_reset |=> (!in_reset || (tx_err_count == 8'h00 && rx_err_count == 8'h00 && stamp_value == 16'h0000
      && err_irq_flags == 8'h00 && test_ctrl == 8'h00 && err_code_low == 7'h00)))
    else $error("initialised register moved in reset mode");

  chk_disp_mode_kept: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (in_reset && !wr_ecode) |=> (err_display_mode == $past(err_display_mode)))
    else $error("display-mode bit lost in reset mode");

  chk_live_flags: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (reg_re_i && reg_addr_i == CRM_ADR_STATE_WORD && !bus_big_endian_i)
      |=> (reg_rdata_o[CRM_SW_SLEEP] == $past(sleep_status_i) && reg_rdata_o[CRM_SW_TX_FIFO] == $past(tx_fifo_status_i)))
    else $error("live status flags not shown");

  chk_big_endian_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (reg_re_i && bus_big_endian_i) |=> (reg_rdata_o == {$past(rd_le[7:0]), $past(rd_le[15:8])}))
    else $error("big-endian read not byte swapped");

  chk_reset_flag_rise: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(in_reset_mode_o) |-> $past(op_mode_request[0]))
    else $error("reset mode reached without a request");

  chk_flag_set_wins: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (!in_reset && err_event_i[0] && next_state != CRM_ST_RESET) |=> err_irq_flags[0])
    else $error("error event lost against a clear");

  cov_graceful_drain: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state == CRM_ST_DRAIN) ##1 (state == CRM_ST_RESET));
  cov_forced_from_drain: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    (state == CRM_ST_DRAIN && op_mode_request == CRM_MODE_FORCED));
  cov_leave_reset: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(in_reset_mode_o));

endmodule : crm_reset_ctrl

// File: bench/crm_can_node.sv
// Behavioural model of the other CAN traffic seen by the reset-mode control block
`timescale 1ns/1ps
module crm_can_node (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic tx_go_i,
  input wire logic rx_go_i,
  input wire logic [7:0] tx_len_i,
  input wire logic [7:0] rx_len_i,
  output logic tx_busy_o,
  output logic rx_busy_o,
  output logic rx_done_o
);
  // ==========================================================================
  // Frame timers
  logic [7:0] tx_cnt;
  logic [7:0] rx_cnt;

  // A frame lasts its programmed cycles; the end of reception gives one done pulse
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
      rx_done_o <= 1'b0;
    end else begin
      tx_cnt <= tx_go_i ? tx_len_i : (tx_cnt != 8'h00 ? tx_cnt - 8'h01 : 8'h00);
      rx_cnt <= rx_go_i ? rx_len_i : (rx_cnt != 8'h00 ? rx_cnt - 8'h01 : 8'h00);
      rx_done_o <= (rx_cnt == 8'h01) && !rx_go_i;
    end
  end

  // Busy flags follow the timers, so they drop the cycle a frame ends
  assign tx_busy_o = (tx_cnt != 8'h00);
  assign rx_busy_o = (rx_cnt != 8'h00);
endmodule : crm_can_node

// File: bench/crm_reset_ctrl_test.sv
// Self-checking testbench of the CAN reset-mode control block
`timescale 1ns/1ps
module crm_reset_ctrl_test import crm_pkg::*;;
  // ==========================================================================
  // Stimulus and observation signals
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic bus_big_endian_i = 1'b0;
  logic tx_busy_i, rx_busy_i, rx_done_i;
  logic sleep_status_i = 1'b0;
  logic tx_fifo_status_i = 1'b0;
  logic [7:0] err_event_i = 8'h00;
  logic rx_err_inc_i = 1'b0;
  logic tx_err_inc_i = 1'b0;
  logic stamp_tick_i = 1'b0;
  logic [7:0] search_result_i = 8'h5a;
  logic in_reset_mode_o;
  logic [1:0] op_mode_o;
  logic tx_go = 1'b0;
  logic rx_go = 1'b0;
  logic [7:0] tx_len = 8'h00;
  logic [7:0] rx_len = 8'h00;
  int error_cnt = 0;
  int comparisons = 0;

  always #50 core_clk_i = ~core_clk_i;

  crm_reset_ctrl dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .bus_big_endian_i(bus_big_endian_i), .tx_busy_i(tx_busy_i), .rx_busy_i(rx_busy_i),
    .rx_done_i(rx_done_i), .sleep_status_i(sleep_status_i), .tx_fifo_status_i(tx_fifo_status_i),
    .err_event_i(err_event_i), .rx_err_inc_i(rx_err_inc_i), .tx_err_inc_i(tx_err_inc_i),
    .stamp_tick_i(stamp_tick_i), .search_result_i(search_result_i),
    .in_reset_mode_o(in_reset_mode_o), .op_mode_o(op_mode_o));

  crm_can_node node_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .tx_go_i(tx_go), .rx_go_i(rx_go),
    .tx_len_i(tx_len), .rx_len_i(rx_len), .tx_busy_o(tx_busy_i), .rx_busy_o(rx_busy_i),
    .rx_done_o(rx_done_i));

  // ==========================================================================
  // Shared bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string msg);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask : rd_chk

  task automatic set_mode(input logic [1:0] m);
    wr(CRM_ADR_MAIN_CTRL, {14'h0000, m});
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : set_mode

  // Every event input pulses for two cycles, so every counter moves by two
  task automatic events2();
    @(posedge core_clk_i);
    {rx_err_inc_i, tx_err_inc_i, stamp_tick_i} <= 3'b111;
    err_event_i <= 8'h05;
    repeat (2) @(posedge core_clk_i);
    {rx_err_inc_i, tx_err_inc_i, stamp_tick_i} <= 3'b000;
    err_event_i <= 8'h00;
  endtask : events2

  task automatic frames(input logic [7:0] tl, input logic [7:0] rl);
    @(posedge core_clk_i);
    {tx_go, rx_go} <= 2'b11;
    tx_len <= tl;
    rx_len <= rl;
    @(posedge core_clk_i);
    {tx_go, rx_go} <= 2'b00;
  endtask : frames

  // ==========================================================================
  // Scenarios
  task automatic t_after_reset();
    chk({15'h0000, in_reset_mode_o}, 16'h0001, "reset flag");
    chk({14'h0000, op_mode_o}, {14'h0000, CRM_MODE_GRACE}, "mode after reset");
    rd_chk(CRM_ADR_STATE_WORD, 16'h0001, "state after reset");
  endtask : t_after_reset

  // Forced entry mid-transmission wipes the listed registers and keeps them wiped
  task automatic t_forced();
    logic [4:0] adr [10] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h10};
    set_mode(CRM_MODE_OPERATE);
    chk({15'h0000, in_reset_mode_o}, 16'h0000, "operate");
    events2();
    wr(CRM_ADR_MBX_BASE, 16'h0001);
    wr(CRM_ADR_ERR_CODE, 16'h0083);
    rd_chk(CRM_ADR_RX_ERR, 16'h0002, "rx count");
    rd_chk(CRM_ADR_STAMP, 16'h0002, "stamp");
    rd_chk(CRM_ADR_SRCH_STAT, 16'h005a, "search copy");
    frames(8'd60, 8'd60);
    wr(CRM_ADR_MAIN_CTRL, {14'h0000, CRM_MODE_FORCED});
    repeat (2) @(posedge core_clk_i);
    #1 chk({15'h0000, in_reset_mode_o}, 16'h0001, "forced entry");
    chk({15'h0000, tx_busy_i}, 16'h0001, "tx still busy");
    foreach (adr[i]) rd_chk(adr[i], 16'h0000, "initialised");
    rd_chk(CRM_ADR_ERR_CODE, 16'h0080, "display mode kept");
    events2();
    wr(CRM_ADR_TEST, 16'h0001);
    foreach (adr[i]) rd_chk(adr[i], 16'h0000, "held in reset");
  endtask : t_forced

  // Graceful entry waits for the transmit frame but not for the receive frame
  task automatic t_graceful();
    int n;
    repeat (70) @(posedge core_clk_i);
    set_mode(CRM_MODE_OPERATE);
    frames(8'd12, 8'd40);
    wr(CRM_ADR_MAIN_CTRL, {14'h0000, CRM_MODE_GRACE});
    rd_chk(CRM_ADR_STATE_WORD, 16'h0006, "draining");
    n = 0;
    while (tx_busy_i === 1'b1 && n < 30) begin
      chk({15'h0000, in_reset_mode_o}, 16'h0000, "waits for tx");
      @(posedge core_clk_i);
      #1 n++;
    end
    repeat (2) @(posedge core_clk_i);
    #1 chk({15'h0000, in_reset_mode_o}, 16'h0001, "entered after tx");
    chk({15'h0000, rx_busy_i}, 16'h0001, "rx not awaited");
  endtask : t_graceful

  task automatic t_live_flags();
    @(posedge core_clk_i);
    {sleep_status_i, tx_fifo_status_i} <= 2'b11;
    rd_chk(CRM_ADR_STATE_WORD, 16'h0031, "live flags set");
    @(posedge core_clk_i);
    {sleep_status_i, tx_fifo_status_i} <= 2'b00;
    rd_chk(CRM_ADR_STATE_WORD, 16'h0001, "live flags clear");
  endtask : t_live_flags

  // Big-endian swaps bytes both ways; an unmapped index reads zero; mode 10 runs like operate
  task automatic t_endian();
    set_mode(CRM_MODE_HALT);
    chk({15'h0000, in_reset_mode_o}, 16'h0000, "halt leaves reset");
    chk({14'h0000, op_mode_o}, 16'h0002, "halt request kept");
    events2();
    bus_big_endian_i <= 1'b1;
    rd_chk(CRM_ADR_STAMP, 16'h0200, "swapped read");
    wr(CRM_ADR_MAIN_CTRL, 16'h0300);
    repeat (2) @(posedge core_clk_i);
    #1 chk({14'h0000, op_mode_o}, 16'h0003, "swapped write");
    chk({15'h0000, in_reset_mode_o}, 16'h0001, "forced by swapped write");
    @(posedge core_clk_i);
    bus_big_endian_i <= 1'b0;
    rd_chk(5'h0c, 16'h0000, "unmapped");
  endtask : t_endian

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    #1 t_after_reset();
    t_forced();
    t_graceful();
    t_live_flags();
    t_endian();
    close_out();
  end

  // The scenarios need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk_i);
    error_cnt++;
    close_out();
  end
endmodule : crm_reset_ctrl_test
